// [csic_cfg.svh]
// Offsets, field positions, reset values and vectors of the status and interrupt control block
`ifndef CSIC_CFG_SVH
`define CSIC_CFG_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CSIC_ADDR_FLAGS 8'h0a
`define CSIC_ADDR_CTRL_PRI 8'h0b
`define CSIC_ADDR_CTRL_SEC 8'h1e
// ----------------------------------------
// Condition flag bit positions
// ----------------------------------------
`define CSIC_BIT_CARRY 0
`define CSIC_BIT_HALF_CARRY 1
`define CSIC_BIT_ZERO 2
`define CSIC_BIT_OVERFLOW 3
`define CSIC_BIT_POWER_DOWN 4
`define CSIC_BIT_WDT_EXPIRED 5
// ----------------------------------------
// Primary control bit positions
// ----------------------------------------
`define CSIC_BIT_MASTER_EN 0
`define CSIC_BIT_EXT0_EN 1
`define CSIC_BIT_EXT1_EN 2
`define CSIC_BIT_TIMER_EN 3
`define CSIC_BIT_EXT0_REQ 4
`define CSIC_BIT_EXT1_REQ 5
`define CSIC_BIT_TIMER_REQ 6
// ----------------------------------------
// Secondary control bit positions
// ----------------------------------------
`define CSIC_BIT_TICK_EN 0
`define CSIC_BIT_CLOCK_EN 1
`define CSIC_BIT_TICK_REQ 4
`define CSIC_BIT_CLOCK_REQ 5
// ----------------------------------------
// Reset values and vectors
// ----------------------------------------
`define CSIC_RESET_BYTE 8'h00
`define CSIC_VEC_EXT0 10'h004
`define CSIC_VEC_EXT1 10'h008
`define CSIC_VEC_TIMER 10'h00c
`define CSIC_VEC_TICK 10'h010
`define CSIC_VEC_CLOCK 10'h014
`endif

// [csic_pkg.sv]
// Types shared by the status and interrupt control block
package csic_pkg;
   typedef enum logic [1:0] {CSIC_ALU_NONE, CSIC_ALU_ADD, CSIC_ALU_SUB, CSIC_ALU_LOGIC} csic_alu_op_type;
   typedef enum logic [2:0] {CSIC_SRC_EXT0, CSIC_SRC_EXT1, CSIC_SRC_TIMER, CSIC_SRC_TICK, CSIC_SRC_CLOCK,
                             CSIC_SRC_NONE} csic_src_type;
endpackage

// [csic_pin_edge.sv]
// Synchroniser and falling edge detector for one external request pin
`timescale 1ns/100ps
module csic_pin_edge
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic pin,
   output logic fall
);
   logic sync_a;
   logic sync_b;
   logic last;
   logic next_sync_a;
   logic next_sync_b;
   logic next_last;

   always_comb
   begin
      next_sync_a = pin;
      next_sync_b = sync_a;
      next_last = sync_b;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         last <= 1'b1;
      end
      else
      begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         last <= next_last;
      end
   end

   assign fall = last & ~sync_b;
endmodule

// [csic_core.sv]
// Condition flags and five-source interrupt control of the core
`timescale 1ns/100ps
`include "csic_cfg.svh"
module csic_core
   import csic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire csic_alu_op_type alu_op,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic alu_carry_in,
   input wire logic alu_use_carry,
   input wire logic [7:0] alu_result,
   input wire logic rotate_carry_valid,
   input wire logic rotate_carry,
   input wire logic watchdog_clear_instr,
   input wire logic halt_instr,
   input wire logic watchdog_timeout,
   input wire logic return_from_irq,
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   input wire logic timer_overflow,
   input wire logic tick_event,
   input wire logic clock_event,
   input wire logic stack_full,
   input wire logic irq_accept,
   output logic irq_request,
   output logic [9:0] irq_vector,
   output logic push_pc,
   output logic wake_up,
   output logic [7:0] condition_flags
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [3:0] arith;
   logic power_down_flag;
   logic watchdog_expired_flag;
   logic [4:0] irq_enable;
   logic master_irq_enable;
   logic [4:0] req_flag;
   logic [3:0] next_arith;
   logic next_power_down_flag;
   logic next_watchdog_expired_flag;
   logic [4:0] next_irq_enable;
   logic next_master_irq_enable;
   logic [4:0] next_req_flag;
   logic [4:0] req_event;
   logic [4:0] ready;
   logic [4:0] grant;
   logic [4:0] wr_flags;
   logic [4:0] wr_en;
   logic ext0_fall;
   logic ext1_fall;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] sum_low7;
   logic wr_status;
   logic wr_pri;
   logic wr_sec;
   logic take;
   csic_src_type src;

   // ----------------------------------------
   // External pins
   // ----------------------------------------
   csic_pin_edge u_ext0
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(ext_irq_pin_0),
      .fall(ext0_fall)
   );
   csic_pin_edge u_ext1
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(ext_irq_pin_1),
      .fall(ext1_fall)
   );
   assign req_event = {clock_event, tick_event, timer_overflow, ext1_fall, ext0_fall};

   // ----------------------------------------
   // Arithmetic
   // ----------------------------------------
   always_comb
   begin
      sum = 9'h000;
      low_sum = 5'h00;
      sum_low7 = 8'h00;
      if (alu_op == CSIC_ALU_SUB)
      begin
         sum = {1'b0, alu_a} + {1'b0, ~alu_b} + {8'h00, (alu_use_carry ? alu_carry_in : 1'b1)};
         low_sum = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + {4'h0, (alu_use_carry ? alu_carry_in : 1'b1)};
         sum_low7 = {1'b0, alu_a[6:0]} + {1'b0, ~alu_b[6:0]} + {7'h00, (alu_use_carry ? alu_carry_in : 1'b1)};
      end
      else
      begin
         sum = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, (alu_use_carry & alu_carry_in)};
         low_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, (alu_use_carry & alu_carry_in)};
         sum_low7 = {1'b0, alu_a[6:0]} + {1'b0, alu_b[6:0]} + {7'h00, (alu_use_carry & alu_carry_in)};
      end
   end

   assign wr_status = reg_write && (reg_addr == `CSIC_ADDR_FLAGS);
   assign wr_pri = reg_write && (reg_addr == `CSIC_ADDR_CTRL_PRI);
   assign wr_sec = reg_write && (reg_addr == `CSIC_ADDR_CTRL_SEC);

   always_comb
   begin
      next_arith = arith;
      if (wr_status)
      begin
         next_arith = reg_wdata[`CSIC_BIT_OVERFLOW:`CSIC_BIT_CARRY];
      end
      if (alu_op == CSIC_ALU_ADD || alu_op == CSIC_ALU_SUB)
      begin
         next_arith[`CSIC_BIT_CARRY] = sum[8];
         next_arith[`CSIC_BIT_HALF_CARRY] = low_sum[4];
         next_arith[`CSIC_BIT_OVERFLOW] = sum_low7[7] ^ sum[8];
      end
      if (alu_op != CSIC_ALU_NONE)
      begin
         next_arith[`CSIC_BIT_ZERO] = (alu_result == 8'h00);
      end
      if (rotate_carry_valid)
      begin
         next_arith[`CSIC_BIT_CARRY] = rotate_carry;
      end
   end

   // ----------------------------------------
   // Power-down and watchdog flags
   // ----------------------------------------
   always_comb
   begin
      next_power_down_flag = power_down_flag;
      next_watchdog_expired_flag = watchdog_expired_flag;
      if (watchdog_clear_instr)
      begin
         next_power_down_flag = 1'b0;
         next_watchdog_expired_flag = 1'b0;
      end
      if (halt_instr)
      begin
         next_power_down_flag = 1'b1;
         next_watchdog_expired_flag = 1'b0;
      end
      if (watchdog_timeout)
      begin
         next_watchdog_expired_flag = 1'b1;
      end
   end

   // ----------------------------------------
   // Priority and acknowledge
   // ----------------------------------------
   assign ready = req_flag & irq_enable & {5{master_irq_enable & ~stack_full}};

   always_comb
   begin
      src = CSIC_SRC_NONE;
      irq_vector = 10'h000;
      if (ready[0])
      begin
         src = CSIC_SRC_EXT0;
         irq_vector = `CSIC_VEC_EXT0;
      end
      else if (ready[1])
      begin
         src = CSIC_SRC_EXT1;
         irq_vector = `CSIC_VEC_EXT1;
      end
      else if (ready[2])
      begin
         src = CSIC_SRC_TIMER;
         irq_vector = `CSIC_VEC_TIMER;
      end
      else if (ready[3])
      begin
         src = CSIC_SRC_TICK;
         irq_vector = `CSIC_VEC_TICK;
      end
      else if (ready[4])
      begin
         src = CSIC_SRC_CLOCK;
         irq_vector = `CSIC_VEC_CLOCK;
      end
   end

   assign irq_request = (src != CSIC_SRC_NONE);
   assign take = irq_request & irq_accept;
   assign push_pc = take;
   assign wake_up = |(req_flag & irq_enable);

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_comb
   begin
      wr_flags = 5'h00;
      wr_en = 5'h00;
      grant = 5'h00;
      if (take)
      begin
         grant[src] = 1'b1;
      end
      if (wr_pri)
      begin
         wr_en[2:0] = 3'h7;
         wr_flags[2:0] = reg_wdata[`CSIC_BIT_TIMER_REQ:`CSIC_BIT_EXT0_REQ];
      end
      if (wr_sec)
      begin
         wr_en[4:3] = 2'h3;
         wr_flags[4:3] = reg_wdata[`CSIC_BIT_CLOCK_REQ:`CSIC_BIT_TICK_REQ];
      end
      next_irq_enable = irq_enable;
      next_master_irq_enable = master_irq_enable;
      if (wr_pri)
      begin
         next_master_irq_enable = reg_wdata[`CSIC_BIT_MASTER_EN];
         next_irq_enable[0] = reg_wdata[`CSIC_BIT_EXT0_EN];
         next_irq_enable[1] = reg_wdata[`CSIC_BIT_EXT1_EN];
         next_irq_enable[2] = reg_wdata[`CSIC_BIT_TIMER_EN];
      end
      if (wr_sec)
      begin
         next_irq_enable[3] = reg_wdata[`CSIC_BIT_TICK_EN];
         next_irq_enable[4] = reg_wdata[`CSIC_BIT_CLOCK_EN];
      end
      if (return_from_irq)
      begin
         next_master_irq_enable = 1'b1;
      end
      if (take)
      begin
         next_master_irq_enable = 1'b0;
      end
   end

   for (genvar i = 0; i < 5; i++)
   begin : g_flag
      always_comb
      begin
         next_req_flag[i] = req_flag[i];
         if (wr_en[i])
         begin
            next_req_flag[i] = wr_flags[i];
         end
         if (grant[i])
         begin
            next_req_flag[i] = 1'b0;
         end
         if (req_event[i])
         begin
            next_req_flag[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         arith <= 4'h0;
         power_down_flag <= 1'b0;
         watchdog_expired_flag <= 1'b0;
         irq_enable <= 5'h00;
         master_irq_enable <= 1'b0;
         req_flag <= 5'h00;
      end
      else
      begin
         arith <= next_arith;
         power_down_flag <= next_power_down_flag;
         watchdog_expired_flag <= next_watchdog_expired_flag;
         irq_enable <= next_irq_enable;
         master_irq_enable <= next_master_irq_enable;
         req_flag <= next_req_flag;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   assign condition_flags = {2'b00, watchdog_expired_flag, power_down_flag, arith};

   always_comb
   begin
      reg_rdata = `CSIC_RESET_BYTE;
      case (reg_addr)
         `CSIC_ADDR_FLAGS: reg_rdata = condition_flags;
         `CSIC_ADDR_CTRL_PRI: reg_rdata = {1'b0, req_flag[2:0], irq_enable[2:0], master_irq_enable};
         `CSIC_ADDR_CTRL_SEC: reg_rdata = {2'b00, req_flag[4:3], 2'b00, irq_enable[4:3]};
         default: reg_rdata = `CSIC_RESET_BYTE;
      endcase
   end
endmodule

// [csic_core_assertions.sv]
// Port checks for the status and interrupt control block
`timescale 1ns/100ps
`include "csic_cfg.svh"
module csic_core_assertions
   import csic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_write,
   input wire csic_alu_op_type alu_op,
   input wire logic [7:0] alu_result,
   input wire logic watchdog_clear_instr,
   input wire logic halt_instr,
   input wire logic watchdog_timeout,
   input wire logic return_from_irq,
   input wire logic stack_full,
   input wire logic irq_accept,
   input wire logic irq_request,
   input wire logic [9:0] irq_vector,
   input wire logic push_pc,
   input wire logic wake_up,
   input wire logic [7:0] condition_flags
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_grant;
      push_pc && !reg_write && !return_from_irq;
   endsequence
   sequence s_halt;
      halt_instr && !watchdog_timeout;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_grant_drops_master: assert property (s_grant |=> !irq_request)
      else $error("request still up after grant");
   a_full_blocks_ack: assert property (stack_full |-> !irq_request && !push_pc)
      else $error("request while stack full");
   a_ready_needs_enable: assert property (irq_request |-> wake_up)
      else $error("request without enabled flag");
   a_accept_pushes: assert property (irq_request && irq_accept |-> push_pc)
      else $error("no push on accept");
   a_vector_legal: assert property (irq_request |-> irq_vector inside {`CSIC_VEC_EXT0, `CSIC_VEC_EXT1,
      `CSIC_VEC_TIMER, `CSIC_VEC_TICK, `CSIC_VEC_CLOCK})
      else $error("bad vector");
   a_top_bits_zero: assert property (condition_flags[7:6] == 2'b00)
      else $error("status top bits set");
   a_halt_marks_pd: assert property (s_halt |=> condition_flags[5:4] == 2'b01)
      else $error("halt flags wrong");
   a_timeout_marks: assert property (watchdog_timeout |=> condition_flags[5])
      else $error("timeout flag not set");
   a_clear_drops_pd: assert property (watchdog_clear_instr && !halt_instr && !watchdog_timeout
      |=> condition_flags[5:4] == 2'b00)
      else $error("clear left power flags");
   a_write_keeps_pd: assert property (reg_write && reg_addr == `CSIC_ADDR_FLAGS && !halt_instr
      && !watchdog_clear_instr && !watchdog_timeout |=> $stable(condition_flags[5:4]))
      else $error("write changed power flags");
   a_zero_on_result: assert property (alu_op != CSIC_ALU_NONE
      |=> condition_flags[2] == ($past(alu_result) == 8'h00))
      else $error("zero flag wrong");
endmodule
bind csic_core csic_core_assertions i_csic_core_assertions (.clk_sys, .rst_n, .reg_addr, .reg_write,
   .alu_op, .alu_result, .watchdog_clear_instr, .halt_instr, .watchdog_timeout, .return_from_irq,
   .stack_full, .irq_accept, .irq_request, .irq_vector, .push_pc, .wake_up, .condition_flags);

// [csic_seq_model.sv]
// Sequencer and four level stack model facing the interrupt logic
`timescale 1ns/100ps
module csic_seq_model
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic irq_request,
   input wire logic push_pc,
   input wire logic return_from_irq,
   input wire logic accept_en,
   output logic irq_accept,
   output logic stack_full
);
   logic [2:0] depth;
   logic [2:0] next_depth;
   always_comb
   begin
      next_depth = depth;
      if (push_pc && depth < 3'h4)
         next_depth = depth + 3'h1;
      else if (return_from_irq && depth != 3'h0)
         next_depth = depth - 3'h1;
      if (!rst_n)
         next_depth = 3'h0;
   end
   always_ff @(posedge clk_sys)
   begin
      depth <= next_depth;
   end
   assign stack_full = depth == 3'h4;
   assign irq_accept = accept_en && irq_request;
endmodule

// [csic_core_test.sv]
// Self-checking bench for the status and interrupt control block
`timescale 1ns/100ps
`include "csic_cfg.svh"
module csic_core_test
   import csic_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, reg_write = 1'b0, pin0 = 1'b1, pin1 = 1'b1, acc = 1'b0, uc = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00, alu_result = 8'h00;
   logic [7:0] ev = 8'h00, ta[4] = '{8'hff, 8'h7f, 8'h05, 8'h00}, tb[4] = '{8'h01, 8'h01, 8'h05, 8'hff};
   logic [3:0] tf[4] = '{4'h7, 4'ha, 4'h7, 4'h7};
   logic [9:0] vec[5] = '{`CSIC_VEC_EXT0, `CSIC_VEC_EXT1, `CSIC_VEC_TIMER, `CSIC_VEC_TICK, `CSIC_VEC_CLOCK};
   csic_alu_op_type alu_op = CSIC_ALU_NONE;
   logic [7:0] reg_rdata, condition_flags;
   logic [9:0] irq_vector;
   logic irq_request, push_pc, wake_up, irq_accept, stack_full;
   int failures = 0, checks_done = 0;
   always #5 clk_sys = ~clk_sys;
   csic_core i_csic_core (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
      .alu_carry_in(uc), .alu_use_carry(uc), .alu_result(alu_result), .rotate_carry_valid(ev[7]),
      .rotate_carry(uc), .watchdog_clear_instr(ev[1]), .halt_instr(ev[0]), .watchdog_timeout(ev[2]),
      .return_from_irq(ev[3]), .ext_irq_pin_0(pin0), .ext_irq_pin_1(pin1), .timer_overflow(ev[4]),
      .tick_event(ev[5]), .clock_event(ev[6]), .stack_full(stack_full), .irq_accept(irq_accept),
      .irq_request(irq_request), .irq_vector(irq_vector), .push_pc(push_pc), .wake_up(wake_up),
      .condition_flags(condition_flags));
   csic_seq_model i_csic_seq_model (.clk_sys(clk_sys), .rst_n(rst_n), .irq_request(irq_request),
      .push_pc(push_pc), .return_from_irq(ev[3]), .accept_en(acc), .irq_accept(irq_accept),
      .stack_full(stack_full));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk_sys);
      reg_write = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      #1;
      chk({2'b00, reg_rdata}, {2'b00, exp});
      @(negedge clk_sys);
   endtask
   task automatic evp(input int i);
      ev[i] = 1'b1;
      @(negedge clk_sys);
      ev[i] = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic give_verdict;
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      #100000;
      failures++;
      give_verdict;
   end
   initial
   begin
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      rd(`CSIC_ADDR_FLAGS, 8'h00);
      rd(`CSIC_ADDR_CTRL_SEC, 8'h00);
      rd(8'h20, 8'h00);
      wr(`CSIC_ADDR_CTRL_PRI, 8'h8f);
      rd(`CSIC_ADDR_CTRL_PRI, 8'h0f);
      wr(`CSIC_ADDR_CTRL_SEC, 8'hcf);
      rd(`CSIC_ADDR_CTRL_SEC, 8'h03);
      wr(`CSIC_ADDR_FLAGS, 8'hff);
      rd(`CSIC_ADDR_FLAGS, 8'h0f);
      wr(`CSIC_ADDR_CTRL_PRI, 8'h00);
      wr(`CSIC_ADDR_CTRL_SEC, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         alu_op = (i == 2) ? CSIC_ALU_SUB : CSIC_ALU_ADD;
         uc = (i == 3);
         alu_a = ta[i];
         alu_b = tb[i];
         alu_result = (i == 2) ? ta[i] - tb[i] : ta[i] + tb[i] + uc;
         @(negedge clk_sys);
         chk({6'h00, condition_flags[3:0]}, {6'h00, tf[i]});
      end
      alu_op = CSIC_ALU_NONE;
      uc = 1'b0;
      evp(7);
      chk({9'h000, condition_flags[0]}, 10'h000);
      uc = 1'b1;
      evp(7);
      chk({9'h000, condition_flags[0]}, 10'h001);
      uc = 1'b0;
      evp(0);
      chk({8'h00, condition_flags[5:4]}, 10'h001);
      evp(2);
      chk({8'h00, condition_flags[5:4]}, 10'h003);
      evp(1);
      chk({8'h00, condition_flags[5:4]}, 10'h000);
      evp(4);
      evp(5);
      evp(6);
      pin0 = 1'b0;
      pin1 = 1'b0;
      repeat (4) @(negedge clk_sys);
      pin0 = 1'b1;
      pin1 = 1'b1;
      rd(`CSIC_ADDR_CTRL_PRI, 8'h70);
      rd(`CSIC_ADDR_CTRL_SEC, 8'h30);
      wr(`CSIC_ADDR_CTRL_PRI, 8'h7e);
      wr(`CSIC_ADDR_CTRL_SEC, 8'h33);
      chk({9'h000, wake_up}, 10'h001);
      chk({9'h000, irq_request}, 10'h000);
      wr(`CSIC_ADDR_CTRL_PRI, 8'h7f);
      for (int i = 0; i < 5; i++)
      begin
         chk(irq_vector, vec[i]);
         acc = 1'b1;
         #1;
         chk({9'h000, push_pc}, 10'h001);
         @(negedge clk_sys);
         acc = 1'b0;
         chk({9'h000, irq_request}, 10'h000);
         evp(3);
      end
      rd(`CSIC_ADDR_CTRL_PRI, 8'h0f);
      rd(`CSIC_ADDR_CTRL_SEC, 8'h03);
      for (int i = 0; i < 4; i++)
      begin
         evp(4);
         wr(`CSIC_ADDR_CTRL_PRI, 8'h4f);
         chk({9'h000, irq_request}, 10'h001);
         acc = 1'b1;
         @(negedge clk_sys);
         acc = 1'b0;
      end
      evp(4);
      wr(`CSIC_ADDR_CTRL_PRI, 8'h4f);
      chk({9'h000, irq_request}, 10'h000);
      rd(`CSIC_ADDR_CTRL_PRI, 8'h4f);
      evp(3);
      chk({9'h000, irq_request}, 10'h001);
      give_verdict;
   end
endmodule
